/* rtl/dbg_status_pkg.sv */
// Package for the debug trace status and control block
// Assumes a byte-wide register file behind a 32-bit classic Wishbone slave
package dbg_status_pkg;
  // Printed offsets are register indices; byte address is four times the index
  localparam logic [7:0] IDX_DEBUG_ARM_CONTROL = 8'h20;
  localparam logic [7:0] IDX_DEBUG_STATUS = 8'h21;
  localparam logic [7:0] IDX_TRACE_CONTROL = 8'h22;
  localparam logic [7:0] IDX_COMPARATOR_MATCH_CONTROL = 8'h23;
  localparam logic [7:0] IDX_TRACE_COUNT = 8'h26;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h31;
  // Field positions
  localparam int ARM_BIT = 7;
  localparam int FULL_BIT = 7;
  localparam int TSRC_BIT = 6;
  localparam int ALIGN_BIT = 0;
  localparam int IRQ_FULL_BIT = 0;
  localparam int IRQ_END_BIT = 1;
  // Reset values
  localparam logic [7:0] TRACE_CONTROL_RST = 8'h00;
  localparam logic [1:0] MATCH_MAP_RST = 2'h0;
  localparam logic [1:0] IRQ_RST = 2'h0;
  // Masks of writable bits
  localparam logic [7:0] TCR_MODE_ALIGN_MASK = 8'h0d;
  // Trace capacity in lines
  localparam int TRACE_LINES = 64;

  // Sequencer states, plain binary codes 1..4 along state1 -> state2 -> state3 -> final
  typedef enum logic [2:0] {
    SEQ_STATE0 = 3'h0,
    SEQ_STATE1 = 3'h1,
    SEQ_STATE2 = 3'h2,
    SEQ_STATE3 = 3'h3,
    SEQ_FINAL = 3'h4
  } seq_state_t;

  typedef enum logic [1:0] {
    TRC_NORMAL = 2'h0,
    TRC_LOOP_SUPPRESS = 2'h1,
    TRC_DETAIL = 2'h2,
    TRC_COMPRESSED_PC = 2'h3
  } trace_mode_t;

  typedef enum logic [1:0] {
    MAP_A_B = 2'h0,
    MAP_INSIDE = 2'h1,
    MAP_OUTSIDE = 2'h2,
    MAP_RESERVED = 2'h3
  } match_map_t;

  typedef struct packed {
    logic trace_source_enable;
    trace_mode_t trace_mode_select;
    logic trigger_align;
  } trace_control_t;

  typedef struct packed {
    logic match0;
    logic match1;
  } match_out_t;
endpackage

/* rtl/debug_trace_status_control.sv */
// Debug trace status and control registers with sequencer and match mapping
// Assumes comparator hits, line stores and session events come synchronous to ref_clk
// Functional notes
// - Full flag sets once 64 or more lines stored since arming.
// - Full flag clears on arming write (arm bit 1) and power-on reset only.
// - Full flag also shows at bit 7 of trace count.
// - Sequencer state field updates on every state transition in session.
// - Software disarm keeps state field at last reached state.
// - Internal session end returns sequencer to state0, field zero.
// - Arming enters state1, field forced to 001.
// - State codes 000..100 map state0..final; 101..111 reserved.
// - Debug status readable always; writes ignored.
// - Trace source requests traced session; refused and inhibited when secured.
// - Bit 6 writable unsecured and disarmed; bits 3,2,0 when disarmed.
// - Trace mode 00 normal, 01 loop suppress, 10 detail, 11 compressed.
// - Mode selects which entries the capture path stores.
// - Align 0 trigger at end, 1 trigger before storing.
// - Match control readable always, writable only while disarmed.
// - Match map 00 A/B, 01 inside, 10 outside, 11 reserved.
// - Arm bit arms and enters state1; clears when session completes.
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ns
module debug_trace_status_control #(
  parameter int CNT_W = 6
) (
  // Clock and resets
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic por_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // System and sequencer events
  input wire logic secured,
  input wire logic line_stored,
  input wire logic seq_advance,
  input wire logic seq_to_final,
  input wire logic session_done,
  input wire logic comp_a_hit,
  input wire logic comp_b_hit,
  input wire logic addr_in_range,
  // Capture path control, match and status outputs
  output logic trace_enable,
  output logic store_cof,
  output logic drop_redundant,
  output logic store_detail,
  output logic store_pc,
  output logic trigger_at_start,
  output dbg_status_pkg::match_out_t match_o,
  output logic armed,
  output logic irq
);
  initial
  begin
    if (CNT_W != 6) $error("CNT_W must be 6 for 64 lines");
  end

  logic [CNT_W-1:0] count_r;
  logic full_r;
  logic armed_r;
  dbg_status_pkg::seq_state_t state_r, state_nxt;
  dbg_status_pkg::trace_control_t tcr_r;
  logic [1:0] map_r;
  logic [1:0] irq_stat_r, irq_mask_r;
  logic ack_r;
  logic [31:0] rdata_r;

  wire bus_req = wb_cyc_i && wb_stb_i && !ack_r;
  wire [7:0] idx = wb_adr_i[9:2];
  wire lane0 = wb_sel_i[0];
  wire wr = bus_req && wb_we_i && lane0;
  wire [7:0] wd = wb_dat_i[7:0];
  wire wr_arm = wr && idx == dbg_status_pkg::IDX_DEBUG_ARM_CONTROL;
  wire wr_tcr = wr && idx == dbg_status_pkg::IDX_TRACE_CONTROL;
  wire wr_map = wr && idx == dbg_status_pkg::IDX_COMPARATOR_MATCH_CONTROL;
  wire wr_istat = wr && idx == dbg_status_pkg::IDX_IRQ_STATUS;
  wire wr_imask = wr && idx == dbg_status_pkg::IDX_IRQ_MASK;
  wire arm_set = wr_arm && wd[dbg_status_pkg::ARM_BIT];
  wire arm_clr = wr_arm && !wd[dbg_status_pkg::ARM_BIT];
  wire count_wrap = armed_r && line_stored && (&count_r);
  wire end_evt = armed_r && session_done && !arm_set;

  wire [7:0] status_rd = {full_r, 4'h0, state_r};
  wire [7:0] count_rd = {full_r, 1'b0, count_r};
  wire [7:0] tcr_rd = {1'b0, tcr_r.trace_source_enable, 2'h0, tcr_r.trace_mode_select, 1'b0, tcr_r.trigger_align};
  logic [7:0] rd_mux;
  always_comb
  begin
    if (idx == dbg_status_pkg::IDX_DEBUG_ARM_CONTROL) rd_mux = {armed_r, 7'h00};
    else if (idx == dbg_status_pkg::IDX_DEBUG_STATUS) rd_mux = status_rd;
    else if (idx == dbg_status_pkg::IDX_TRACE_CONTROL) rd_mux = tcr_rd;
    else if (idx == dbg_status_pkg::IDX_COMPARATOR_MATCH_CONTROL) rd_mux = {6'h00, map_r};
    else if (idx == dbg_status_pkg::IDX_TRACE_COUNT) rd_mux = count_rd;
    else if (idx == dbg_status_pkg::IDX_IRQ_STATUS) rd_mux = {6'h00, irq_stat_r};
    else if (idx == dbg_status_pkg::IDX_IRQ_MASK) rd_mux = {6'h00, irq_mask_r};
    else rd_mux = 8'h00;
  end

  // One wait-free cycle: ack the cycle after the strobe, drop it next
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0;
    end
    else
    begin
      ack_r <= bus_req;
      rdata_r <= {24'h0, rd_mux};
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  always_ff @(posedge ref_clk or negedge por_n)
  begin
    if (!por_n)
    begin
      full_r <= 1'b0;
      count_r <= '0;
    end
    else if (arm_set)
    begin
      full_r <= 1'b0;
      count_r <= '0;
    end
    else if (armed_r && line_stored)
    begin
      count_r <= count_r + 1'b1;
      if (count_wrap) full_r <= 1'b1;
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    if (arm_set) state_nxt = dbg_status_pkg::SEQ_STATE1;
    else if (end_evt) state_nxt = dbg_status_pkg::SEQ_STATE0;
    else if (armed_r && !arm_clr)
    begin
      case (state_r)
        dbg_status_pkg::SEQ_STATE1:
        begin
          if (seq_to_final) state_nxt = dbg_status_pkg::SEQ_FINAL;
          else if (seq_advance) state_nxt = dbg_status_pkg::SEQ_STATE2;
        end
        dbg_status_pkg::SEQ_STATE2:
        begin
          if (seq_to_final) state_nxt = dbg_status_pkg::SEQ_FINAL;
          else if (seq_advance) state_nxt = dbg_status_pkg::SEQ_STATE3;
        end
        dbg_status_pkg::SEQ_STATE3:
        begin
          if (seq_advance || seq_to_final) state_nxt = dbg_status_pkg::SEQ_FINAL;
        end
        dbg_status_pkg::SEQ_STATE0, dbg_status_pkg::SEQ_FINAL: state_nxt = state_r;
        default: state_nxt = dbg_status_pkg::SEQ_STATE0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      armed_r <= 1'b0;
      state_r <= dbg_status_pkg::SEQ_STATE0;
    end
    else
    begin
      armed_r <= arm_set ? 1'b1 : (arm_clr || end_evt) ? 1'b0 : armed_r;
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tcr_r <= dbg_status_pkg::TRACE_CONTROL_RST[3:0];
      map_r <= dbg_status_pkg::MATCH_MAP_RST;
    end
    else
    begin
      if (wr_tcr && !armed_r && !secured) tcr_r.trace_source_enable <= wd[dbg_status_pkg::TSRC_BIT];
      else if (secured) tcr_r.trace_source_enable <= 1'b0;
      if (wr_tcr && !armed_r)
      begin
        tcr_r.trace_mode_select <= dbg_status_pkg::trace_mode_t'(wd[3:2]);
        tcr_r.trigger_align <= wd[dbg_status_pkg::ALIGN_BIT];
      end
      if (wr_map && !armed_r) map_r <= wd[1:0];
    end
  end

  // Event flags; a set in the clear cycle wins
  wire [1:0] irq_set = {end_evt, count_wrap && !full_r};
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_stat_r <= dbg_status_pkg::IRQ_RST;
      irq_mask_r <= dbg_status_pkg::IRQ_RST;
    end
    else
    begin
      irq_stat_r <= (irq_stat_r & ~(wr_istat ? wd[1:0] : 2'h0)) | irq_set;
      if (wr_imask) irq_mask_r <= wd[1:0];
    end
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  assign trace_enable = tcr_r.trace_source_enable && !secured && armed_r;
  assign store_cof = trace_enable && (tcr_r.trace_mode_select == dbg_status_pkg::TRC_NORMAL
    || tcr_r.trace_mode_select == dbg_status_pkg::TRC_LOOP_SUPPRESS);
  assign drop_redundant = trace_enable && tcr_r.trace_mode_select == dbg_status_pkg::TRC_LOOP_SUPPRESS;
  assign store_detail = trace_enable && tcr_r.trace_mode_select == dbg_status_pkg::TRC_DETAIL;
  assign store_pc = trace_enable && tcr_r.trace_mode_select == dbg_status_pkg::TRC_COMPRESSED_PC;
  assign trigger_at_start = tcr_r.trigger_align;
  assign armed = armed_r;

  // match mapping; reserved code acts as 00
  wire map_range = map_r == dbg_status_pkg::MAP_INSIDE || map_r == dbg_status_pkg::MAP_OUTSIDE;
  assign match_o.match0 = map_r == dbg_status_pkg::MAP_INSIDE ? addr_in_range :
    map_r == dbg_status_pkg::MAP_OUTSIDE ? !addr_in_range : comp_a_hit;
  assign match_o.match1 = map_range ? 1'b0 : comp_b_hit;

  // buffer reads depend on software ordering only; nothing enforced here

  property p_arm_state1;
    @(posedge ref_clk) disable iff (!rst_n) arm_set |=> (state_r == dbg_status_pkg::SEQ_STATE1 && armed_r);
  endproperty
  a_arm_state1: assert property (p_arm_state1) else $error("arm did not enter state1");
  property p_full_clear;
    @(posedge ref_clk) disable iff (!por_n) arm_set |=> !full_r;
  endproperty
  a_full_clear: assert property (p_full_clear) else $error("full flag not cleared by arm");
  property p_full_set;
    @(posedge ref_clk) disable iff (!por_n) (count_wrap && !arm_set) |=> full_r;
  endproperty
  a_full_set: assert property (p_full_set) else $error("full flag missed 64 lines");
  property p_mirror;
    @(posedge ref_clk) disable iff (!rst_n) status_rd[7] == count_rd[7];
  endproperty
  a_mirror: assert property (p_mirror) else $error("full flag mirror mismatch");
  property p_no_reserved;
    @(posedge ref_clk) disable iff (!rst_n) state_r <= dbg_status_pkg::SEQ_FINAL;
  endproperty
  a_no_reserved: assert property (p_no_reserved) else $error("reserved sequencer code");
  property p_disarm_keep;
    @(posedge ref_clk) disable iff (!rst_n) (armed_r && arm_clr && !end_evt) |=> state_r == $past(state_r);
  endproperty
  a_disarm_keep: assert property (p_disarm_keep) else $error("disarm altered state field");
  property p_end_state0;
    @(posedge ref_clk) disable iff (!rst_n) end_evt |=> (state_r == dbg_status_pkg::SEQ_STATE0 && !armed_r);
  endproperty
  a_end_state0: assert property (p_end_state0) else $error("internal end not state0");
  property p_secure_src;
    @(posedge ref_clk) disable iff (!rst_n) secured |=> !tcr_r.trace_source_enable && !trace_enable;
  endproperty
  a_secure_src: assert property (p_secure_src) else $error("trace source set while secured");
  property p_map_locked;
    @(posedge ref_clk) disable iff (!rst_n) armed_r && !arm_clr && !end_evt |=> $stable(map_r);
  endproperty
  a_map_locked: assert property (p_map_locked) else $error("match control changed while armed");
  property p_range_map;
    @(posedge ref_clk) disable iff (!rst_n) map_range |-> !match_o.match1;
  endproperty
  a_range_map: assert property (p_range_map) else $error("match1 active in range mode");

  property p_ack_answer;
    @(posedge ref_clk) disable iff (!rst_n) (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not acknowledged");

  property p_status_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (bus_req && !wb_we_i && idx == dbg_status_pkg::IDX_DEBUG_STATUS) |=> wb_dat_o[7:0] == $past(status_rd);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read data wrong");

  property p_count_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (bus_req && !wb_we_i && idx == dbg_status_pkg::IDX_TRACE_COUNT) |=> wb_dat_o[7] == $past(full_r);
  endproperty
  a_count_read: assert property (p_count_read) else $error("count read lost full flag");

  property p_full_hold;
    @(posedge ref_clk) disable iff (!por_n) (full_r && !arm_set) |=> full_r;
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("full flag dropped without arm");

  property p_count_step;
    @(posedge ref_clk) disable iff (!por_n)
      (armed_r && line_stored && !arm_set) |=> count_r == CNT_W'($past(count_r) + 1'b1);
  endproperty
  a_count_step: assert property (p_count_step) else $error("line count did not step");

  property p_state_step;
    @(posedge ref_clk) disable iff (!rst_n) (armed_r && !arm_set && !arm_clr && !end_evt
      && state_r == dbg_status_pkg::SEQ_STATE1 && seq_advance && !seq_to_final) |=> state_r == dbg_status_pkg::SEQ_STATE2;
  endproperty
  a_state_step: assert property (p_state_step) else $error("sequencer missed advance");

  property p_final_jump;
    @(posedge ref_clk) disable iff (!rst_n) (armed_r && !arm_set && !arm_clr && !end_evt && seq_to_final
      && state_r != dbg_status_pkg::SEQ_STATE0 && state_r != dbg_status_pkg::SEQ_FINAL) |=> state_r == dbg_status_pkg::SEQ_FINAL;
  endproperty
  a_final_jump: assert property (p_final_jump) else $error("sequencer missed final jump");

  property p_disarmed_hold;
    @(posedge ref_clk) disable iff (!rst_n) (!armed_r && !arm_set) |=> $stable(state_r);
  endproperty
  a_disarmed_hold: assert property (p_disarmed_hold) else $error("state moved while disarmed");

  property p_tsrc_locked;
    @(posedge ref_clk) disable iff (!rst_n) (armed_r && !secured) |=> $stable(tcr_r.trace_source_enable);
  endproperty
  a_tsrc_locked: assert property (p_tsrc_locked) else $error("trace source changed while armed");

  property p_mode_locked;
    @(posedge ref_clk) disable iff (!rst_n) armed_r |=> $stable(tcr_r.trace_mode_select) && $stable(tcr_r.trigger_align);
  endproperty
  a_mode_locked: assert property (p_mode_locked) else $error("trace mode changed while armed");

  property p_mode_decode;
    @(posedge ref_clk) disable iff (!rst_n)
      trace_enable |-> $onehot({store_cof && !drop_redundant, drop_redundant, store_detail, store_pc});
  endproperty
  a_mode_decode: assert property (p_mode_decode) else $error("capture decode not one hot");

  property p_secure_inhibit;
    @(posedge ref_clk) disable iff (!rst_n) secured |-> !trace_enable;
  endproperty
  a_secure_inhibit: assert property (p_secure_inhibit) else $error("tracing while secured");

  property p_map_a_b;
    @(posedge ref_clk) disable iff (!rst_n)
      map_r == dbg_status_pkg::MAP_A_B |-> (match_o.match0 == comp_a_hit && match_o.match1 == comp_b_hit);
  endproperty
  a_map_a_b: assert property (p_map_a_b) else $error("direct match mapping wrong");

  property p_disarm;
    @(posedge ref_clk) disable iff (!rst_n) (arm_clr && !arm_set) |=> !armed_r;
  endproperty
  a_disarm: assert property (p_disarm) else $error("disarm write ignored");

  c_arm: cover property (@(posedge ref_clk) disable iff (!rst_n) arm_set);
  c_final: cover property (@(posedge ref_clk) disable iff (!rst_n) state_r == dbg_status_pkg::SEQ_FINAL);
  c_full: cover property (@(posedge ref_clk) disable iff (!por_n) $rose(full_r));
  c_irq: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(irq));
  c_wrap: cover property (@(posedge ref_clk) disable iff (!por_n) count_wrap);
endmodule

/* verification/debug_trace_status_control_bench.sv */
// Self-checking bench for the debug trace status and control block
// Assumes the block's one-cycle Wishbone ack and the index map of its package
`timescale 1ns/1ns
module debug_trace_status_control_bench;
  localparam logic [7:0] A_ARM = dbg_status_pkg::IDX_DEBUG_ARM_CONTROL;
  localparam logic [7:0] A_ST = dbg_status_pkg::IDX_DEBUG_STATUS;
  localparam logic [7:0] A_TCR = dbg_status_pkg::IDX_TRACE_CONTROL;
  localparam logic [7:0] A_MAP = dbg_status_pkg::IDX_COMPARATOR_MATCH_CONTROL;
  localparam logic [7:0] A_CNT = dbg_status_pkg::IDX_TRACE_COUNT;
  localparam logic [7:0] A_IRQ = dbg_status_pkg::IDX_IRQ_STATUS;
  localparam logic [7:0] A_MSK = dbg_status_pkg::IDX_IRQ_MASK;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic por_n = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [9:0] wb_adr_i = 10'h000;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic secured = 1'b0, line_stored = 1'b0, seq_advance = 1'b0, seq_to_final = 1'b0, session_done = 1'b0;
  logic comp_a_hit = 1'b0, comp_b_hit = 1'b0, addr_in_range = 1'b0;
  logic trace_enable, store_cof, drop_redundant, store_detail, store_pc, trigger_at_start, armed, irq;
  dbg_status_pkg::match_out_t match_o;
  int n_fail = 0;
  int checks = 0;
  logic [7:0] rd;
  logic [3:0] mode_exp [4] = '{4'h8, 4'hc, 4'h2, 4'h1};

  always #50 ref_clk = ~ref_clk;

  debug_trace_status_control dut (.ref_clk(ref_clk), .rst_n(rst_n), .por_n(por_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .secured(secured), .line_stored(line_stored),
    .seq_advance(seq_advance), .seq_to_final(seq_to_final), .session_done(session_done),
    .comp_a_hit(comp_a_hit), .comp_b_hit(comp_b_hit), .addr_in_range(addr_in_range),
    .trace_enable(trace_enable), .store_cof(store_cof), .drop_redundant(drop_redundant),
    .store_detail(store_detail), .store_pc(store_pc), .trigger_at_start(trigger_at_start),
    .match_o(match_o), .armed(armed), .irq(irq));

  task automatic end_of_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Holds the request until ack is sampled; a lost ack ends the run
  task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= {24'h000000, d};
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1)
    begin
      check("wb_ack_o", 32'(wb_ack_o), 32'h1);
      end_of_test();
    end
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rdchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    check(what, 32'(rd), 32'(exp));
  endtask

  // One-cycle event pulse: 0 line, 1 advance, 2 final, 3 session end
  task automatic pulse(input int k);
    @(posedge ref_clk);
    line_stored <= (k == 0);
    seq_advance <= (k == 1);
    seq_to_final <= (k == 2);
    session_done <= (k == 3);
    @(posedge ref_clk);
    {line_stored, seq_advance, seq_to_final, session_done} <= 4'h0;
  endtask

  task automatic t_reset;
    rdchk("debug_status", A_ST, 8'h00);
    rdchk("trace_control", A_TCR, 8'h00);
    wr(A_ST, 8'hff);
    rdchk("debug_status", A_ST, 8'h00);
    rdchk("unmapped", 8'h3f, 8'h00);
  endtask

  task automatic t_seq;
    wr(A_ARM, 8'h80);
    check("armed", 32'(armed), 32'h1);
    rdchk("state", A_ST, 8'h01);
    for (int i = 0; i < 3; i++)
    begin
      pulse(1);
      rdchk("state", A_ST, 8'(i + 2));
    end
    wr(A_ARM, 8'h00);
    rdchk("state", A_ST, 8'h04);
    wr(A_ARM, 8'h80);
    rdchk("state", A_ST, 8'h01);
    pulse(2);
    rdchk("state", A_ST, 8'h04);
    pulse(3);
    rdchk("state", A_ST, 8'h00);
    check("armed", 32'(armed), 32'h0);
    check("irq", 32'(irq), 32'h0);
    wr(A_MSK, 8'h02);
    check("irq", 32'(irq), 32'h1);
    wr(A_IRQ, 8'h02);
    check("irq", 32'(irq), 32'h0);
  endtask

  task automatic t_modes;
    for (int m = 0; m < 4; m++)
    begin
      // source set before any buffer use
      wr(A_TCR, 8'(8'h40 | (m << 2)));
      wr(A_ARM, 8'h80);
      check("decode", 32'({store_cof, drop_redundant, store_detail, store_pc}), 32'(mode_exp[m]));
      check("trace_enable", 32'(trace_enable), 32'h1);
      wr(A_TCR, 8'h00);
      rdchk("trace_control", A_TCR, 8'(8'h40 | (m << 2)));
      wr(A_MAP, 8'h01);
      rdchk("match_control", A_MAP, 8'h00);
      wr(A_ARM, 8'h00);
    end
  endtask

  task automatic t_secure;
    @(posedge ref_clk);
    secured <= 1'b1;
    wr(A_TCR, 8'h41);
    rdchk("trace_control", A_TCR, 8'h01);
    check("trigger_at_start", 32'(trigger_at_start), 32'h1);
    wr(A_ARM, 8'h80);
    check("trace_enable", 32'(trace_enable), 32'h0);
    wr(A_ARM, 8'h00);
    secured <= 1'b0;
    wr(A_TCR, 8'h00);
    check("trigger_at_start", 32'(trigger_at_start), 32'h0);
  endtask

  // Code 11 is expected to act as 00
  task automatic t_match;
    logic [1:0] e;
    for (int c = 0; c < 4; c++)
    begin
      wr(A_MAP, 8'(c));
      rdchk("match_control", A_MAP, 8'(c));
      for (int v = 0; v < 8; v++)
      begin
        @(posedge ref_clk);
        {addr_in_range, comp_b_hit, comp_a_hit} <= 3'(v);
        @(posedge ref_clk);
        e = (c == 1) ? {v[2], 1'b0} : (c == 2) ? {~v[2], 1'b0} : {v[0], v[1]};
        check("match_o", 32'(match_o), 32'(e));
      end
    end
  endtask

  task automatic t_full;
    wr(A_MSK, 8'h01);
    wr(A_ARM, 8'h80);
    repeat (63) pulse(0);
    rdchk("debug_status", A_ST, 8'h01);
    check("irq", 32'(irq), 32'h0);
    pulse(0);
    rdchk("debug_status", A_ST, 8'h81);
    rdchk("trace_count", A_CNT, 8'h80);
    check("irq", 32'(irq), 32'h1);
    wr(A_IRQ, 8'h01);
    check("irq", 32'(irq), 32'h0);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    @(posedge ref_clk);
    rst_n <= 1'b1;
    rdchk("debug_status", A_ST, 8'h80);
    rdchk("trace_count", A_CNT, 8'h80);
    wr(A_ARM, 8'h80);
    rdchk("debug_status", A_ST, 8'h01);
    repeat (64) pulse(0);
    wr(A_ARM, 8'h00);
    rdchk("debug_status", A_ST, 8'h81);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    por_n <= 1'b0;
    @(posedge ref_clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    rdchk("debug_status", A_ST, 8'h00);
    rdchk("trace_count", A_CNT, 8'h00);
  endtask

  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    t_reset();
    t_seq();
    t_modes();
    t_secure();
    t_match();
    t_full();
    end_of_test();
  end
endmodule
